//--- cit_params.svh
// Register map, field positions, reset values and timing for the camera input trigger block
`ifndef CIT_PARAMS_SVH
`define CIT_PARAMS_SVH

// Register addresses on the camera bus
`define CIT_ADDR_INP1 32'hf1000300
`define CIT_ADDR_INP2 32'hf1000304
`define CIT_ADDR_DLY_INQ 32'hf0f00534
`define CIT_ADDR_DLY_CTRL 32'hf0f00834

// Input control fields
`define CIT_BIT_PRESENCE 0
`define CIT_BIT_POLARITY 7
`define CIT_FUNC_LSB 11
`define CIT_FUNC_MSB 15
`define CIT_BIT_PIN 31

// Input function codes
`define CIT_FN_OFF 5'h00
`define CIT_FN_TRIG 5'h02
`define CIT_FN_STEP 5'h06
`define CIT_FN_SRST 5'h07

// Delay control fields
`define CIT_BIT_ABS 1
`define CIT_BIT_ONOFF 6
`define CIT_VAL_LSB 20
`define CIT_VAL_MSB 31

// Delay inquiry fields and contents
`define CIT_INQ_FLAG_MSB 7
`define CIT_INQ_MIN_LSB 8
`define CIT_INQ_MIN_MSB 19
`define CIT_INQ_MAX_LSB 20
`define CIT_INQ_MAX_MSB 31
`define CIT_INQ_FLAGS 8'hbb
`define CIT_INQ_MIN 12'h000
`define CIT_INQ_MAX 12'hfff

// Reset values
`define CIT_RST_POL 1'b1
`define CIT_RST_FUNC_FIRST 5'h02
`define CIT_RST_FUNC_OTHER 5'h00
`define CIT_RST_DLY_ON 1'b0
`define CIT_RST_ABS 1'b0
`define CIT_RST_VALUE 12'h000

// Delay time base: one value step, in ns, and the clock period in ns
`define CIT_TIME_BASE_NS 1000
`define CIT_CLK_PERIOD_NS 20
`define CIT_TB_CYCLES ((`CIT_TIME_BASE_NS + `CIT_CLK_PERIOD_NS - 1) / `CIT_CLK_PERIOD_NS)

`endif

//--- cit_pkg.sv
// Types for the camera input trigger block
`default_nettype none
`include "cit_params.svh"

package cit_pkg;

    // Delay sequencer states
    typedef enum logic [2:0]
    {
        CIT_IDLE = 3'b001,
        CIT_WAIT = 3'b010,
        CIT_FIRE = 3'b100
    } cit_state_type;

    // Input function codes
    typedef enum logic [4:0]
    {
        CIT_FUNC_OFF = `CIT_FN_OFF,
        CIT_FUNC_TRIG = `CIT_FN_TRIG,
        CIT_FUNC_STEP = `CIT_FN_STEP,
        CIT_FUNC_SRST = `CIT_FN_SRST
    } cit_func_type;

endpackage
`default_nettype wire

//--- cit_input_cond.sv
// Conditioning of one isolated camera input
`timescale 1ns/10ps
`default_nettype none
`include "cit_params.svh"

module cit_input_cond
    import cit_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic pin_raw_i,
    input wire logic polarity_i,
    input wire logic [4:0] func_i,
    output logic readback_o,
    output logic vote_o,
    output logic is_trig_o,
    output logic seq_step_o,
    output logic seq_reset_o
);

    logic opto_n;
    logic active;
    logic active_q;
    logic active_rise;

    // Isolator inverts, internal negation restores the pin level
    assign opto_n = ~pin_raw_i;
    assign active = polarity_i ? readback_o : ~readback_o;
    assign active_rise = active & ~active_q;
    assign is_trig_o = (func_i == `CIT_FN_TRIG);

    // Level readback, active level and sequence pulses
    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            readback_o <= 1'b0;
            active_q <= 1'b0;
            vote_o <= 1'b0;
            seq_step_o <= 1'b0;
            seq_reset_o <= 1'b0;
        end
        else
        begin
            readback_o <= ~opto_n;
            active_q <= active;
            vote_o <= active;
            seq_step_o <= active_rise & (func_i == `CIT_FN_STEP);
            seq_reset_o <= active_rise & (func_i == `CIT_FN_SRST);
        end
    end

endmodule
`default_nettype wire

//--- cit_delay_timer.sv
// Trigger delay timer counting in time-base steps
`timescale 1ns/10ps
`default_nettype none
`include "cit_params.svh"

module cit_delay_timer
    import cit_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic load_i,
    input wire logic [11:0] units_i,
    output logic busy_o,
    output logic done_o
);

    localparam logic [15:0] TB_LAST = 16'(`CIT_TB_CYCLES - 1);

    logic [15:0] div;
    logic [11:0] units;
    logic tick;

    // Time-base enable pulse from the divider
    assign tick = busy_o & (div == TB_LAST);

    // Load, count down per time-base step, end with a done pulse
    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            div <= 16'h0000;
            units <= 12'h000;
            busy_o <= 1'b0;
            done_o <= 1'b0;
        end
        else
        begin
            done_o <= 1'b0;
            if (load_i)
            begin
                div <= 16'h0000;
                units <= units_i;
                busy_o <= 1'b1;
            end
            else if (busy_o && units == 12'h000)
            begin
                busy_o <= 1'b0;
                done_o <= 1'b1;
            end
            else if (busy_o)
            begin
                div <= tick ? 16'h0000 : div + 16'h0001;
                units <= tick ? units - 12'h001 : units;
            end
        end
    end

endmodule
`default_nettype wire

//--- cit_trigger_ctrl.sv
// Camera input trigger control: registers, trigger combining and delay
//
// Contract
// - Input control bit 7 selects polarity
// - Function codes: off, trigger, step, reset
// - Bit 31 reads current input pin level
// - Negation after isolator: open input reads 0
// - Trigger is AND of trigger-function inputs
// - Feature register bit 0 reports presence
// - Delay control bit 0 reads available
// - Delay value sits in bits 20-31
// - Inquiry capability flags are read-only
// - Inquiry holds minimum and maximum delay
// - Absolute bit picks external absolute value
// - Delay control bit 6 switches delay
// - Two identical input control registers; function resets to trigger on the first, off on the second
`timescale 1ns/10ps
`default_nettype none
`include "cit_params.svh"

module cit_trigger_ctrl
    import cit_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [31:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    output logic [31:0] reg_rdata_o,
    output logic reg_ack_o,
    input wire logic [1:0] pin_raw_i,
    input wire logic ext_trig_mode_i,
    input wire logic [11:0] abs_delay_value_i,
    output logic trigger_level_o,
    output logic capture_start_o,
    output logic [1:0] seq_step_o,
    output logic [1:0] seq_reset_o
);

    // Per-input control state
    logic [1:0] pol;
    logic [4:0] func [2];
    logic [1:0] readback;
    logic [1:0] vote;
    logic [1:0] is_trig;
    logic [31:0] inp_rdata [2];
    logic [1:0] hit_inp;
    logic [1:0] vote_ok;

    // Delay control state
    logic dly_on;
    logic dly_abs;
    logic [11:0] dly_value;

    // Sequencer
    cit_state_type state;
    cit_state_type next_state;
    logic trig_q;
    logic trig_rise;
    logic timer_load;
    logic timer_busy;
    logic timer_done;
    logic [11:0] dly_units;

    // Address decode
    logic hit_inq;
    logic hit_ctrl;
    logic wr_ctrl;
    logic [31:0] inq_rdata;
    logic [31:0] ctrl_rdata;
    logic [31:0] next_rdata;

    assign hit_inq = (reg_addr_i == `CIT_ADDR_DLY_INQ);
    assign hit_ctrl = (reg_addr_i == `CIT_ADDR_DLY_CTRL);
    assign hit_inp[0] = (reg_addr_i == `CIT_ADDR_INP1);
    assign hit_inp[1] = (reg_addr_i == `CIT_ADDR_INP2);
    assign wr_ctrl = reg_wr_i & hit_ctrl;

    // Per-input register and conditioning, identical for both inputs except the function reset value (first input trigger, second off)
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_inp
            logic wr_inp;

            assign wr_inp = reg_wr_i & hit_inp[gi];

            // Polarity and function fields, writable by the host
            always_ff @(posedge clk_sys_i)
            begin
                if (srst_i)
                begin
                    pol[gi] <= `CIT_RST_POL;
                    func[gi] <= (gi == 0) ? `CIT_RST_FUNC_FIRST : `CIT_RST_FUNC_OTHER;
                end
                else if (wr_inp)
                begin
                    pol[gi] <= reg_wdata_i[`CIT_BIT_POLARITY];
                    func[gi] <= reg_wdata_i[`CIT_FUNC_MSB:`CIT_FUNC_LSB];
                end
            end

            // Read image: presence, polarity, function, pin level
            always_comb
            begin
                inp_rdata[gi] = 32'h00000000;
                inp_rdata[gi][`CIT_BIT_PRESENCE] = 1'b1;
                inp_rdata[gi][`CIT_BIT_POLARITY] = pol[gi];
                inp_rdata[gi][`CIT_FUNC_MSB:`CIT_FUNC_LSB] = func[gi];
                inp_rdata[gi][`CIT_BIT_PIN] = readback[gi];
            end

            cit_input_cond u_cond
            (
                .clk_sys_i(clk_sys_i),
                .srst_i(srst_i),
                .pin_raw_i(pin_raw_i[gi]),
                .polarity_i(pol[gi]),
                .func_i(func[gi]),
                .readback_o(readback[gi]),
                .vote_o(vote[gi]),
                .is_trig_o(is_trig[gi]),
                .seq_step_o(seq_step_o[gi]),
                .seq_reset_o(seq_reset_o[gi])
            );
        end
    endgenerate

    // Delay control register
    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            dly_on <= `CIT_RST_DLY_ON;
            dly_abs <= `CIT_RST_ABS;
            dly_value <= `CIT_RST_VALUE;
        end
        else if (wr_ctrl)
        begin
            dly_on <= reg_wdata_i[`CIT_BIT_ONOFF];
            dly_abs <= reg_wdata_i[`CIT_BIT_ABS];
            dly_value <= reg_wdata_i[`CIT_VAL_MSB:`CIT_VAL_LSB];
        end
    end

    // Read images of the delay registers
    assign inq_rdata = {`CIT_INQ_MAX, `CIT_INQ_MIN, `CIT_INQ_FLAGS};
    always_comb
    begin
        ctrl_rdata = 32'h00000000;
        ctrl_rdata[`CIT_BIT_PRESENCE] = 1'b1;
        ctrl_rdata[`CIT_BIT_ABS] = dly_abs;
        ctrl_rdata[`CIT_BIT_ONOFF] = dly_on;
        ctrl_rdata[`CIT_VAL_MSB:`CIT_VAL_LSB] = dly_value;
    end

    // Read select; unmapped addresses read zero
    assign next_rdata = hit_inp[0] ? inp_rdata[0] :
                        hit_inp[1] ? inp_rdata[1] :
                        hit_inq ? inq_rdata :
                        hit_ctrl ? ctrl_rdata : 32'h00000000;

    // Register answer one cycle after the request
    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            reg_rdata_o <= 32'h00000000;
            reg_ack_o <= 1'b0;
        end
        else
        begin
            reg_ack_o <= reg_rd_i | reg_wr_i;
            reg_rdata_o <= reg_rd_i ? next_rdata : reg_rdata_o;
        end
    end

    // Non-trigger inputs never block the AND; vote is the pure active level, so a function change makes no edge
    assign vote_ok = vote | ~is_trig;

    // Combined trigger: AND of all trigger inputs, none means no trigger
    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            trigger_level_o <= 1'b0;
            trig_q <= 1'b0;
        end
        else
        begin
            trigger_level_o <= (|is_trig) & (&vote_ok);
            trig_q <= trigger_level_o;
        end
    end

    assign trig_rise = trigger_level_o & ~trig_q;
    assign dly_units = dly_abs ? abs_delay_value_i : dly_value;
    assign timer_load = (state == CIT_IDLE) & trig_rise & ext_trig_mode_i & dly_on;
    assign capture_start_o = (state == CIT_FIRE);

    // Sequencer next state; edges outside external mode are ignored
    always_comb
    begin
        case (state)
            CIT_IDLE:
                if (trig_rise && ext_trig_mode_i)
                    next_state = dly_on ? CIT_WAIT : CIT_FIRE;
                else
                    next_state = CIT_IDLE;
            CIT_WAIT:
                next_state = timer_done ? CIT_FIRE : CIT_WAIT;
            CIT_FIRE:
                next_state = CIT_IDLE;
            default:
                next_state = CIT_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
            state <= CIT_IDLE;
        else
            state <= next_state;
    end

    cit_delay_timer u_timer
    (
        .clk_sys_i(clk_sys_i),
        .srst_i(srst_i),
        .load_i(timer_load),
        .units_i(dly_units),
        .busy_o(timer_busy),
        .done_o(timer_done)
    );

    // Checks
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (srst_i);

    sequence trig_edge_s;
        (state == CIT_IDLE) && trig_rise && ext_trig_mode_i;
    endsequence

    sequence delayed_start_s;
        trig_edge_s ##0 dly_on;
    endsequence

    sequence abs_zero_s;
        delayed_start_s ##0 dly_abs && abs_delay_value_i == 12'h000;
    endsequence

    sequence two_idle_s;
        is_trig == 2'b11 && readback[1] != pol[1] ##1 is_trig == 2'b11;
    endsequence

    pin_readback_a: assert property ($past(pin_raw_i[0]) == readback[0] || $past(srst_i))
        else $error("input one readback does not follow pin");

    pin_two_a: assert property ($past(pin_raw_i[1]) == readback[1] || $past(srst_i))
        else $error("input two readback does not follow pin");

    pol_write_a: assert property (reg_wr_i && hit_inp[1] |=> pol[1] == $past(reg_wdata_i[`CIT_BIT_POLARITY]))
        else $error("input two polarity not stored");

    trig_and_a: assert property (two_idle_s |=> !trigger_level_o)
        else $error("trigger raised with one trigger input inactive");

    step_decode_a: assert property (seq_step_o[1] |-> $past(func[1]) == `CIT_FN_STEP)
        else $error("sequence step pulse with wrong function");

    seq_reset_a: assert property (seq_reset_o[1] |-> $past(func[1]) == `CIT_FN_SRST)
        else $error("sequence reset pulse with wrong function");

    no_ext_a: assert property ((state == CIT_IDLE) && !ext_trig_mode_i |=> state == CIT_IDLE)
        else $error("capture sequence left idle without external mode");

    direct_start_a: assert property (trig_edge_s ##0 !dly_on |=> capture_start_o ##1 !capture_start_o)
        else $error("undelayed capture not started at once");

    delay_hold_a: assert property (delayed_start_s |=> state == CIT_WAIT ##1 !capture_start_o)
        else $error("delayed capture started too early");

    onoff_write_a: assert property (wr_ctrl |=> dly_on == $past(reg_wdata_i[`CIT_BIT_ONOFF]))
        else $error("delay switch not stored");

    inq_read_a: assert property (reg_rd_i && hit_inq |=> reg_ack_o && reg_rdata_o == 32'hfff000bb)
        else $error("inquiry register content wrong");

    presence_a: assert property (reg_rd_i && (hit_ctrl || hit_inp != 2'b00) |=> reg_rdata_o[0])
        else $error("presence bit not set");

    wait_busy_a: assert property (state == CIT_WAIT && !timer_done |-> timer_busy)
        else $error("waiting for delay with timer stopped");

    zero_delay_a: assert property (abs_zero_s |=> ##1 timer_done ##1 capture_start_o)
        else $error("zero absolute delay not taken");

    abs_write_a: assert property (wr_ctrl |=> dly_abs == $past(reg_wdata_i[`CIT_BIT_ABS]))
        else $error("absolute select not stored");

    no_trig_a: assert property (is_trig == 2'b00 |=> !trigger_level_o)
        else $error("trigger raised with no trigger input");

    reset_quiet_a: assert property ($past(srst_i) |-> ##1 !trigger_level_o && !capture_start_o)
        else $error("trigger or capture right after reset");

endmodule
`default_nettype wire

//--- cit_host_model.sv
// Host model issuing quadlet accesses and trigger mode
`timescale 1ns/10ps
`default_nettype none

module cit_host_model
(
    input wire logic clk_sys_i,
    input wire logic [31:0] reg_rdata_i,
    input wire logic reg_ack_i,
    output logic reg_wr_o,
    output logic reg_rd_o,
    output logic [31:0] reg_addr_o,
    output logic [31:0] reg_wdata_o,
    output logic ext_trig_mode_o,
    output logic [11:0] abs_delay_value_o
);
    // Idle bus, camera not yet in external trigger mode
    initial
    begin
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        reg_addr_o = 32'h00000000;
        reg_wdata_o = 32'h00000000;
        ext_trig_mode_o = 1'b0;
        abs_delay_value_o = 12'h000;
    end

    // Trigger mode and absolute value, changed off the sampling edge
    task automatic set_mode(input logic m, input logic [11:0] v);
        @(negedge clk_sys_i);
        ext_trig_mode_o = m;
        abs_delay_value_o = v;
    endtask

    // One quadlet access; released address and data lines show the inverse of the last value, strobes return low
    task automatic access(input logic wr, input logic [31:0] a, input logic [31:0] d,
                          output logic [31:0] q, output logic ok);
        ok = 1'b0;
        q = 32'h00000000;
        @(negedge clk_sys_i);
        reg_wr_o = wr;
        reg_rd_o = ~wr;
        reg_addr_o = a;
        reg_wdata_o = d;
        @(negedge clk_sys_i);
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        reg_addr_o = ~a;
        reg_wdata_o = ~d;
        for (int i = 0; i < 4 && !ok; i++)
        begin
            if (reg_ack_i === 1'b1)
            begin
                ok = 1'b1;
                q = reg_rdata_i;
            end
            else
                @(negedge clk_sys_i);
        end
    endtask
endmodule

`default_nettype wire

//--- tb_cit_trigger_ctrl.sv
// Self-checking testbench for the camera input trigger block
`timescale 1ns/10ps
`default_nettype none
`include "cit_params.svh"

module tb_cit_trigger_ctrl;
    localparam logic [31:0] a_in1 = `CIT_ADDR_INP1;
    localparam logic [31:0] a_in2 = `CIT_ADDR_INP2;
    localparam logic [31:0] a_inq = `CIT_ADDR_DLY_INQ;
    localparam logic [31:0] a_ctl = `CIT_ADDR_DLY_CTRL;
    localparam int tb_cyc = `CIT_TB_CYCLES;
    logic clk_sys_i = 1'b0;
    logic srst_i = 1'b1;
    logic reg_wr, reg_rd, reg_ack, ext_trig, trig_level, cap_start;
    logic [31:0] reg_addr, reg_wdata, reg_rdata;
    logic [1:0] pin_raw = 2'b00;
    logic [1:0] seq_step, seq_reset;
    logic [11:0] abs_val;
    int n_errors = 0;
    int num_checks = 0;
    int n;

    // Clock
    always #10 clk_sys_i = ~clk_sys_i;

    // Device and host
    cit_trigger_ctrl u_cit_trigger_ctrl (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .reg_wr_i(reg_wr),
        .reg_rd_i(reg_rd), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata),
        .reg_ack_o(reg_ack), .pin_raw_i(pin_raw), .ext_trig_mode_i(ext_trig),
        .abs_delay_value_i(abs_val), .trigger_level_o(trig_level), .capture_start_o(cap_start),
        .seq_step_o(seq_step), .seq_reset_o(seq_reset));
    cit_host_model u_cit_host_model (.clk_sys_i(clk_sys_i), .reg_rdata_i(reg_rdata), .reg_ack_i(reg_ack),
        .reg_wr_o(reg_wr), .reg_rd_o(reg_rd), .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata),
        .ext_trig_mode_o(ext_trig), .abs_delay_value_o(abs_val));

    // Verdict and end of run
    task automatic end_sim();
        if (n_errors == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Compare and count
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Register access with bounded wait for the answer
    task automatic acc(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
        logic ok;
        u_cit_host_model.access(w, a, d, q, ok);
        if (!ok)
        begin
            n_errors++;
            end_sim();
        end
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        acc(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] exp, input string what);
        logic [31:0] q;
        acc(1'b0, a, 32'h00000000, q);
        chk(what, q, exp);
    endtask

    // Drive pins, then wait a fixed count
    task automatic pins(input logic [1:0] p, input int c);
        @(negedge clk_sys_i);
        pin_raw = p;
        repeat (c) @(negedge clk_sys_i);
    endtask

    // Cycles from pin change to capture start, -1 if none
    task automatic cap(input logic [1:0] p, output int k);
        @(negedge clk_sys_i);
        pin_raw = p;
        k = -1;
        for (int i = 1; i <= 300 && k < 0; i++)
        begin
            @(negedge clk_sys_i);
            if (cap_start === 1'b1)
                k = i;
        end
        pins(2'b00, 4);
    endtask

    // Main sequence
    initial
    begin
        repeat (4) @(negedge clk_sys_i);
        srst_i = 1'b0;
        rd(a_in1, 32'h00001081, "in1 reset");
        rd(a_in2, 32'h00000081, "in2 reset");
        rd(a_inq, 32'hfff000bb, "inquiry");
        rd(a_ctl, 32'h00000001, "ctl reset");
        wr(a_inq, 32'h00000000);
        rd(a_inq, 32'hfff000bb, "inquiry ro");
        wr(a_ctl, 32'hffffffff);
        rd(a_ctl, 32'hfff00043, "ctl fields");
        wr(a_ctl, 32'h00000000);
        rd(a_ctl, 32'h00000001, "ctl clear");
        wr(a_in1, 32'hfffffffe);
        rd(a_in1, 32'h0000f881, "in1 fields");
        rd(32'hf1000308, 32'h00000000, "unmapped");
        pins(2'b10, 2);
        rd(a_in2, 32'h80000081, "in2 pin");
        pins(2'b00, 2);
        rd(a_in2, 32'h00000081, "in2 open");
        // Both inputs trigger, second one low active
        wr(a_in1, 32'h00001080);
        wr(a_in2, 32'h00001000);
        pins(2'b01, 3);
        chk("and both", 32'(trig_level), 32'h1);
        pins(2'b11, 3);
        chk("and one", 32'(trig_level), 32'h0);
        wr(a_in2, 32'h00001880);
        pins(2'b01, 3);
        chk("reserved off", 32'(trig_level), 32'h1);
        pins(2'b00, 3);
        wr(a_in2, 32'h00000000);
        // Capture start with and without delay
        cap(2'b01, n);
        chk("no ext mode", 32'(n), 32'hffffffff);
        u_cit_host_model.set_mode(1'b1, 12'h001);
        cap(2'b01, n);
        chk("delay off", 32'(n), 32'd4);
        wr(a_ctl, 32'h00200040);
        cap(2'b01, n);
        chk("delay value", 32'(n), 32'(6 + 2 * tb_cyc));
        wr(a_ctl, 32'h00300042);
        cap(2'b01, n);
        chk("delay abs", 32'(n), 32'(6 + tb_cyc));
        u_cit_host_model.set_mode(1'b1, 12'h000);
        cap(2'b01, n);
        chk("delay abs zero", 32'(n), 32'd6);
        // Sequence step and reset pulses on input two
        wr(a_in2, 32'h00003080);
        pins(2'b10, 2);
        chk("seq step", {30'h0, seq_step}, 32'h2);
        pins(2'b00, 3);
        wr(a_in2, 32'h00003880);
        pins(2'b10, 2);
        chk("seq reset", {30'h0, seq_reset}, 32'h2);
        // Reset in mid-run: no false trigger edge once released
        @(negedge clk_sys_i);
        srst_i = 1'b1;
        repeat (4) @(negedge clk_sys_i);
        srst_i = 1'b0;
        cap(2'b00, n);
        chk("reset quiet", 32'(n), 32'hffffffff);
        rd(a_in2, 32'h00000081, "in2 after reset");
        end_sim();
    end
endmodule

`default_nettype wire
